// file: core/hub_status_indicator_jog.sv
// Purpose: Lamp driving, drive selection and jog keys of the drive hub
// Assumes: All inputs synchronous to clk_sys_in; keys are debounced
// Notes: Lamp outputs are active high and registered
`timescale 1ns/100ps

// How it works
// - Eight drive ports behind one address
// - No line: link, activity lamps dark
// - Line: green lit, yellow flickers 10 Hz on activity
// - Data exchange keeps bus-fault lamp dark
// - Attached without exchange: bus-fault blinks 2 Hz
// - No network: bus-fault lamp steady
// - Watchdog, fault or diagnostic: status lamp steady
// - Signal request: status lamp 2 Hz, 3 s
// - Selector zero collective, else single drive
// - Back key jogs with second set
// - Forward key jogs with first set
// - Bus run commands only at selector zero
// - Presence test: red/green alternate 5 Hz
// - Required comm error: steady red
// - Required drive error: red plus green
// - Extra drives, no error: green 2 Hz
// - Extra drive error: red+green 2 Hz
// - Only required present: steady green
// - Single view: off, red, both, green
// - Presence test repeatable on request
module hub_status_indicator_jog #(
  parameter int NUM_DRIVES = hub_ind_pkg::NUM_DRIVES,
  parameter int NUM_PORTS = hub_ind_pkg::NUM_PORTS,
  parameter int ACT_HALF_CYC = hub_ind_pkg::ACT_HALF_CYC,
  parameter int SLOW_HALF_CYC = hub_ind_pkg::SLOW_HALF_CYC,
  parameter int PRES_HALF_CYC = hub_ind_pkg::PRES_HALF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [NUM_DRIVES-1:0] drive_present_in,
  input wire logic [NUM_DRIVES-1:0] drive_required_in,
  input wire logic [NUM_DRIVES-1:0] drive_comm_err_in,
  input wire logic [NUM_DRIVES-1:0] drive_err_in,
  input wire logic presence_test_in,
  input wire logic [NUM_PORTS-1:0] port_link_in,
  input wire logic [NUM_PORTS-1:0] port_activity_in,
  input wire logic net_connected_in,
  input wire logic data_exchange_in,
  input wire logic status_fault_in,
  input wire logic signal_request_in,
  input wire logic [hub_ind_pkg::SEL_W-1:0] drive_selector_in,
  input wire logic jog_back_key_in,
  input wire logic jog_forward_key_in,
  input wire logic bus_run_request_in,
  output logic [NUM_PORTS-1:0] port_link_lamp_out,
  output logic [NUM_PORTS-1:0] port_activity_lamp_out,
  output logic bus_fault_lamp_out,
  output logic status_fault_lamp_out,
  output logic rs485_red_out,
  output logic rs485_green_out,
  output logic bus_run_enable_out,
  output logic jog_start_out,
  output logic [1:0] jog_set_out,
  output logic [hub_ind_pkg::SEL_W-1:0] jog_drive_out
);
  localparam logic [4:0] SIG_HALVES = 5'(hub_ind_pkg::SIGNAL_HALVES);

  // ----------------------------------------------------------------
  // Blink sources
  // ----------------------------------------------------------------
  logic act_phase;
  logic slow_phase;
  logic slow_tog;
  logic pres_phase;

  blink_divider #(.HALF_CYC(ACT_HALF_CYC)) u_act (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .phase_out(act_phase),
    .toggle_out()
  );
  blink_divider #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .phase_out(slow_phase),
    .toggle_out(slow_tog)
  );
  blink_divider #(.HALF_CYC(PRES_HALF_CYC)) u_pres (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .phase_out(pres_phase),
    .toggle_out()
  );

  // ----------------------------------------------------------------
  // Drive summary
  // ----------------------------------------------------------------
  logic req_ce;
  logic req_de;
  logic extra_any;
  logic extra_de;

  drive_lamp_eval #(.N(NUM_DRIVES)) u_eval (
    .present_in(drive_present_in),
    .required_in(drive_required_in),
    .comm_err_in(drive_comm_err_in),
    .drive_err_in(drive_err_in),
    .req_comm_err_out(req_ce),
    .req_drive_err_out(req_de),
    .extra_present_out(extra_any),
    .extra_drive_err_out(extra_de)
  );

  // ----------------------------------------------------------------
  // Signal service timer
  // ----------------------------------------------------------------
  logic [4:0] sig_left;
  logic [4:0] next_sig_left;
  logic sig_req_d;
  logic next_sig_req_d;

  always_comb begin
    next_sig_req_d = signal_request_in;
    next_sig_left = sig_left;
    if (signal_request_in && !sig_req_d) begin
      next_sig_left = SIG_HALVES;
    end else if (slow_tog && sig_left != 5'h00) begin
      next_sig_left = sig_left - 5'h01;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sig_left <= 5'h00;
      sig_req_d <= 1'b0;
    end else begin
      sig_left <= next_sig_left;
      sig_req_d <= next_sig_req_d;
    end
  end

  // ----------------------------------------------------------------
  // Lamp selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LAMP_OFF = 3'b000,
    LAMP_RED = 3'b001,
    LAMP_BOTH = 3'b010,
    LAMP_GREEN = 3'b011,
    LAMP_ALT = 3'b100,
    LAMP_BLINK_G = 3'b101,
    LAMP_BLINK_B = 3'b110
  } lamp_mode_t;

  lamp_mode_t mode;
  logic [hub_ind_pkg::SEL_W-1:0] sel_idx;
  logic sel_in_range;
  logic s_pres;
  logic s_req;
  logic s_ce;
  logic s_de;

  assign sel_idx = drive_selector_in - 4'h1;
  assign sel_in_range = (32'(drive_selector_in) <= NUM_DRIVES);
  assign s_pres = sel_in_range & drive_present_in[sel_idx[2:0]];
  assign s_req = sel_in_range & drive_required_in[sel_idx[2:0]];
  assign s_ce = sel_in_range & drive_comm_err_in[sel_idx[2:0]];
  assign s_de = sel_in_range & drive_err_in[sel_idx[2:0]];

  // Pick the RS485 lamp mode from view and drive state
  always_comb begin
    mode = LAMP_OFF;
    if (drive_selector_in == hub_ind_pkg::SEL_COLLECTIVE) begin
      if (presence_test_in) begin
        mode = LAMP_ALT;
      end else if (req_ce) begin
        mode = LAMP_RED;
      end else if (req_de) begin
        mode = LAMP_BOTH;
      end else if (extra_any && extra_de) begin
        mode = LAMP_BLINK_B;
      end else if (extra_any) begin
        mode = LAMP_BLINK_G;
      end else begin
        mode = LAMP_GREEN;
      end
    end else begin
      if (!s_pres && !s_req) begin
        mode = LAMP_OFF;
      end else if (s_ce || !s_pres) begin
        mode = LAMP_RED;
      end else if (s_de) begin
        mode = LAMP_BOTH;
      end else begin
        mode = LAMP_GREEN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lamp registers
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] next_link_lamp;
  logic [NUM_PORTS-1:0] next_act_lamp;
  logic next_bf;
  logic next_sf;
  logic next_red;
  logic next_green;

  always_comb begin
    // dark without line; flicker on traffic
    next_link_lamp = port_link_in;
    next_act_lamp = port_link_in & port_activity_in & {NUM_PORTS{act_phase}};
    if (!net_connected_in) begin
      next_bf = 1'b1;
    end else if (data_exchange_in) begin
      next_bf = 1'b0;
    end else begin
      next_bf = slow_phase;
    end
    if (sig_left != 5'h00) begin
      next_sf = slow_phase;
    end else begin
      next_sf = status_fault_in;
    end
    case (mode)
      LAMP_OFF: begin
        next_red = 1'b0;
        next_green = 1'b0;
      end
      LAMP_RED: begin
        next_red = 1'b1;
        next_green = 1'b0;
      end
      LAMP_BOTH: begin
        next_red = 1'b1;
        next_green = 1'b1;
      end
      LAMP_GREEN: begin
        next_red = 1'b0;
        next_green = 1'b1;
      end
      LAMP_ALT: begin
        next_red = pres_phase;
        next_green = ~pres_phase;
      end
      LAMP_BLINK_G: begin
        next_red = 1'b0;
        next_green = slow_phase;
      end
      LAMP_BLINK_B: begin
        next_red = slow_phase;
        next_green = slow_phase;
      end
      default: begin
        next_red = 1'b0;
        next_green = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_link_lamp_out <= '0;
      port_activity_lamp_out <= '0;
      bus_fault_lamp_out <= 1'b1;
      status_fault_lamp_out <= 1'b0;
      rs485_red_out <= 1'b0;
      rs485_green_out <= 1'b0;
    end else begin
      port_link_lamp_out <= next_link_lamp;
      port_activity_lamp_out <= next_act_lamp;
      bus_fault_lamp_out <= next_bf;
      status_fault_lamp_out <= next_sf;
      rs485_red_out <= next_red;
      rs485_green_out <= next_green;
    end
  end

  // ----------------------------------------------------------------
  // Jog keys and run inhibit
  // ----------------------------------------------------------------
  logic back_d;
  logic fwd_d;
  logic next_jog_start;
  logic [1:0] next_jog_set;
  logic next_run_enable;

  // one of eight drives; key edges start jogs
  always_comb begin
    next_jog_start = 1'b0;
    next_jog_set = jog_set_out;
    next_run_enable = bus_run_request_in
        && (drive_selector_in == hub_ind_pkg::SEL_COLLECTIVE);
    if (drive_selector_in != hub_ind_pkg::SEL_COLLECTIVE && sel_in_range) begin
      if (jog_back_key_in && !back_d) begin
        next_jog_start = 1'b1;
        next_jog_set = hub_ind_pkg::JOG_SET_BACK;
      end else if (jog_forward_key_in && !fwd_d) begin
        next_jog_start = 1'b1;
        next_jog_set = hub_ind_pkg::JOG_SET_FWD;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      back_d <= 1'b0;
      fwd_d <= 1'b0;
      jog_start_out <= 1'b0;
      jog_set_out <= hub_ind_pkg::JOG_SET_NONE;
      jog_drive_out <= '0;
      bus_run_enable_out <= 1'b0;
    end else begin
      back_d <= jog_back_key_in;
      fwd_d <= jog_forward_key_in;
      jog_start_out <= next_jog_start;
      jog_set_out <= next_jog_set;
      jog_drive_out <= drive_selector_in;
      bus_run_enable_out <= next_run_enable;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_bf_steady;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    !net_connected_in |=> bus_fault_lamp_out;
  endproperty
  a_bf_steady: assert property (p_bf_steady)
    else $error("bus fault lamp not lit without network");

  property p_bf_dark;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    net_connected_in && data_exchange_in |=> !bus_fault_lamp_out;
  endproperty
  a_bf_dark: assert property (p_bf_dark)
    else $error("bus fault lamp lit during exchange");

  property p_link_dark;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    !port_link_in[0] |=> !port_link_lamp_out[0] && !port_activity_lamp_out[0];
  endproperty
  a_link_dark: assert property (p_link_dark)
    else $error("port lamps lit without line");

  property p_run_gate;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    bus_run_enable_out |-> $past(drive_selector_in) == 4'h0;
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("run enabled with selector nonzero");

  property p_pres_alt;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    drive_selector_in == 4'h0 && presence_test_in
      |=> rs485_red_out != rs485_green_out;
  endproperty
  a_pres_alt: assert property (p_pres_alt)
    else $error("presence lamp not alternating");

  property p_req_red;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    drive_selector_in == 4'h0 && !presence_test_in && req_ce
      |=> rs485_red_out && !rs485_green_out;
  endproperty
  a_req_red: assert property (p_req_red)
    else $error("required comm error not steady red");

  sequence s_back_press;
    !jog_back_key_in ##1 jog_back_key_in && drive_selector_in == 4'h1;
  endsequence
  property p_jog_back;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    s_back_press |=> jog_start_out && jog_set_out == 2'h2;
  endproperty
  a_jog_back: assert property (p_jog_back)
    else $error("back key did not start second set jog");

  sequence s_sig_start;
    !signal_request_in ##1 signal_request_in;
  endsequence
  property p_sig_active;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    s_sig_start |=> sig_left == SIG_HALVES;
  endproperty
  a_sig_active: assert property (p_sig_active)
    else $error("signal timer not loaded");
endmodule // hub_status_indicator_jog

// file: core/hub_ind_pkg.sv
// Purpose: Shared constants for the hub status indicator and jog block
// Assumes: 100 MHz system clock
// Notes: Blink periods are given as full on/off cycle frequencies
package hub_ind_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int NUM_DRIVES = 8;
  localparam int SEL_W = 4;
  localparam int NUM_PORTS = 2;
  // Blink rates in Hz and signal duration in seconds
  localparam int ACT_HZ = 10;
  localparam int SLOW_HZ = 2;
  localparam int PRES_HZ = 5;
  localparam int SIGNAL_SEC = 3;
  // Half-period counts (toggle interval) derived from the clock rate
  localparam int ACT_HALF_CYC = CLK_HZ / (2 * ACT_HZ);
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam int PRES_HALF_CYC = CLK_HZ / (2 * PRES_HZ);
  // Signal service lasts this many slow half periods (3 s at 2 Hz)
  localparam int SIGNAL_HALVES = SIGNAL_SEC * 2 * SLOW_HZ;
  localparam logic [SEL_W-1:0] SEL_COLLECTIVE = 4'h0;
  // Jog parameter sets
  localparam logic [1:0] JOG_SET_FWD = 2'h1;
  localparam logic [1:0] JOG_SET_BACK = 2'h2;
  localparam logic [1:0] JOG_SET_NONE = 2'h0;
endpackage

// file: core/blink_divider.sv
// Purpose: Produces a square-wave blink phase and a toggle pulse
// Assumes: Single system clock, asynchronous active-low reset
// Notes: Phase toggles every HALF_CYC cycles
`timescale 1ns/100ps
module blink_divider #(
  parameter int HALF_CYC = 5_000_000
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  output logic phase_out,
  output logic toggle_out
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic phase;
  logic next_phase;

  // Count cycles and flip the phase at each half period
  always_comb begin
    next_count = count + CW'(1);
    next_phase = phase;
    if (count == LAST) begin
      next_count = '0;
      next_phase = ~phase;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= '0;
      phase <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
    end
  end

  assign phase_out = phase;
  assign toggle_out = (count == LAST);
endmodule // blink_divider

// file: core/drive_lamp_eval.sv
// Purpose: Collective RS485 lamp evaluation over all drives
// Assumes: Per-drive status inputs are steady levels
// Notes: Purely combinational summary for the main block
`timescale 1ns/100ps
module drive_lamp_eval #(
  parameter int N = 8
) (
  input wire logic [N-1:0] present_in,
  input wire logic [N-1:0] required_in,
  input wire logic [N-1:0] comm_err_in,
  input wire logic [N-1:0] drive_err_in,
  output logic req_comm_err_out,
  output logic req_drive_err_out,
  output logic extra_present_out,
  output logic extra_drive_err_out
);
  logic [N-1:0] req_ce;
  logic [N-1:0] req_de;
  logic [N-1:0] extra;
  logic [N-1:0] extra_de;

  // Per-drive classification
  for (genvar i = 0; i < N; i++) begin : g_drive
    assign req_ce[i] = required_in[i] & (comm_err_in[i] | ~present_in[i]);
    assign req_de[i] = required_in[i] & present_in[i] & ~comm_err_in[i]
                       & drive_err_in[i];
    assign extra[i] = ~required_in[i] & present_in[i];
    assign extra_de[i] = extra[i] & drive_err_in[i];
  end

  assign req_comm_err_out = |req_ce;
  assign req_drive_err_out = |req_de;
  assign extra_present_out = |extra;
  assign extra_drive_err_out = |extra_de;
endmodule // drive_lamp_eval

// file: tb/hub_field_model.sv
// Purpose: Drives and fieldbus controller seen from the hub
// Assumes: Bench calls the tasks just after a falling clock edge
// Notes: Levels hold until the next call
`timescale 1ns/100ps
module hub_field_model (
  output logic [7:0] present_out,
  output logic [7:0] required_out,
  output logic [7:0] comm_err_out,
  output logic [7:0] drive_err_out,
  output logic presence_test_out,
  output logic [1:0] link_out,
  output logic [1:0] activity_out,
  output logic net_out,
  output logic exchange_out,
  output logic fault_out,
  output logic signal_out
);
  // ------------------------------------------------------------
  // Drive side
  // ------------------------------------------------------------
  // controller marks required
  task automatic set_drives(input logic [7:0] p, r, c, e, input logic t);
    present_out = p;
    required_out = r;
    comm_err_out = c & r;
    drive_err_out = e & p;
    presence_test_out = t;
  endtask
  // Network side, exchange only while attached
  task automatic set_net(input logic [1:0] l, a, input logic n, x, f, s);
    link_out = l;
    activity_out = a;
    net_out = n;
    exchange_out = x & n;
    fault_out = f;
    signal_out = s;
  endtask
  // Idle levels at time zero
  initial begin
    set_drives(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    set_net(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
  end
endmodule // hub_field_model

// file: tb/hub_status_indicator_jog_tb.sv
// Purpose: Self-checking bench for the hub lamp and jog block
// Assumes: Short blink parameters 4, 10, 6 cycles
// Notes: Lamp patterns are judged by values seen and edge counts
`timescale 1ns/100ps
module hub_status_indicator_jog_tb;
  localparam int W = 60;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] pres, req, cerr, derr;
  logic ptest, net, dx, sfault, sigreq, bf, sf, red, green, run_en, jstart;
  logic [1:0] link, act, link_l, act_l, jset;
  logic [3:0] jdrv;
  logic [3:0] sel = 4'h0;
  logic kb = 1'b0;
  logic kf = 1'b0;
  logic run = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  integer seed = 32'hfaf8a9f8;

  // Clock at 100 MHz
  always #5 clk_sys_in = ~clk_sys_in;

  hub_field_model i_field (.present_out(pres), .required_out(req),
    .comm_err_out(cerr), .drive_err_out(derr), .presence_test_out(ptest),
    .link_out(link), .activity_out(act), .net_out(net), .exchange_out(dx),
    .fault_out(sfault), .signal_out(sigreq));

  hub_status_indicator_jog #(.ACT_HALF_CYC(4), .SLOW_HALF_CYC(10),
    .PRES_HALF_CYC(6)) i_dut (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .drive_present_in(pres),
    .drive_required_in(req), .drive_comm_err_in(cerr), .drive_err_in(derr),
    .presence_test_in(ptest), .port_link_in(link), .port_activity_in(act),
    .net_connected_in(net), .data_exchange_in(dx), .status_fault_in(sfault),
    .signal_request_in(sigreq), .drive_selector_in(sel),
    .jog_back_key_in(kb), .jog_forward_key_in(kf), .bus_run_request_in(run),
    .port_link_lamp_out(link_l), .port_activity_lamp_out(act_l),
    .bus_fault_lamp_out(bf), .status_fault_lamp_out(sf),
    .rs485_red_out(red), .rs485_green_out(green),
    .bus_run_enable_out(run_en), .jog_start_out(jstart),
    .jog_set_out(jset), .jog_drive_out(jdrv));

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rate(input int got, input int lo);
    total_checks++;
    if (got < lo || got > lo + (lo > 0)) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  // Gathers lamp values seen and edges; exp is {edge floor, seen mask}
  task automatic observe(input int k, input logic [7:0] exp);
    logic [1:0] v, pv;
    logic [3:0] seen;
    int edges;
    seen = 4'h0;
    edges = 0;
    pv = 2'h0;
    for (int i = 0; i < W; i++) begin
      @(negedge clk_sys_in);
      case (k)
        0: v = {red, green};
        1: v = {1'b0, bf};
        2: v = {1'b0, sf};
        default: v = {link_l[k-3], act_l[k-3]};
      endcase
      if (i > 0 && v !== pv) edges++;
      pv = v;
      seen = seen | (4'h1 << v);
    end
    chk_val({4'h0, seen}, {4'h0, exp[3:0]});
    chk_rate(edges, int'(exp[7:4]));
  endtask

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  function automatic logic [7:0] exp_rs();
    logic [7:0] bad, ext;
    int d;
    bad = req & (cerr | ~pres);
    ext = pres & ~req;
    d = int'(sel) - 1;
    if (sel != 4'h0) begin
      if (!pres[d] && !req[d]) return 8'h01;
      if (bad[d]) return 8'h04;
      return derr[d] ? 8'h08 : 8'h02;
    end
    if (ptest) return 8'h96;
    if (bad != 8'h00) return 8'h04;
    if ((req & derr) != 8'h00) return 8'h08;
    if ((ext & derr) != 8'h00) return 8'h59;
    return (ext != 8'h00) ? 8'h53 : 8'h02;
  endfunction
  function automatic logic [7:0] exp_bf();
    if (!net) return 8'h02;
    return dx ? 8'h01 : 8'h53;
  endfunction
  function automatic logic [7:0] exp_port(input int j);
    if (!link[j]) return 8'h01;
    return act[j] ? 8'hec : 8'h04;
  endfunction
  // One key press; held six cycles so a held key must pulse once on drives 1 to 8, never at selector 0 or 9
  task automatic jog(input logic [3:0] s, input int k);
    int n;
    logic ok;
    logic [1:0] want;
    n = 0;
    ok = (s != 4'h0 && s <= 4'h8);
    @(negedge clk_sys_in);
    sel = s;
    @(negedge clk_sys_in);
    want = ok ? ((k == 1) ? 2'h1 : 2'h2) : jset;
    kb = (k != 1);
    kf = (k != 0);
    repeat (6) begin
      @(negedge clk_sys_in);
      if (jstart === 1'b1) n++;
    end
    kb = 1'b0;
    kf = 1'b0;
    chk_val(8'(n), {7'h00, ok});
    chk_val({2'h0, jset, jdrv}, {2'h0, want, s});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] r, x, p, c, e;
    int mode;
    repeat (3) @(negedge clk_sys_in);
    chk_val({bf, sf, red, green, jstart, run_en, jset}, 8'h80);
    chk_val({link_l, act_l, jdrv}, 8'h00);
    reset_n_in = 1'b1;
    for (int i = 0; i < 24; i++) begin
      mode = i % 6;
      r = 8'($random(seed));
      x = 8'($random(seed)) & ~r;
      c = 8'h00;
      e = 8'h00;
      p = (mode == 5) ? r : (r | x);
      if (mode == 1) c = r & 8'($random(seed));
      if (mode == 2) e = r & 8'($random(seed));
      if (mode == 3) e = x & 8'($random(seed));
      if (mode == 4) p = p & ~(r & 8'($random(seed))); // Required absent
      @(negedge clk_sys_in);
      sel = (i < 12 || mode == 0) ? 4'h0 : 4'(($random(seed) & 255) % 9);
      i_field.set_drives(p, r, c, e, mode == 0);
      i_field.set_net(2'($random(seed)), 2'($random(seed)),
        1'($random(seed)), 1'($random(seed)), 1'b0, 1'b0);
      repeat (3) @(negedge clk_sys_in);
      observe(0, exp_rs());
      observe(1, exp_bf());
      observe(3, exp_port(0));
      observe(4, exp_port(1));
    end
    i_field.set_net(2'h3, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    repeat (3) @(negedge clk_sys_in);
    observe(2, 8'h02);
    i_field.set_net(2'h3, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge clk_sys_in);
    observe(2, 8'h01);
    i_field.set_net(2'h3, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (2) @(negedge clk_sys_in);
    observe(2, 8'h53);
    repeat (80) @(negedge clk_sys_in);
    observe(2, 8'h02);
    for (int s = 0; s < 10; s++) begin
      for (int k = 0; k < 3; k++) begin
        jog(4'(s), k);
      end
    end
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys_in);
      run = 1'($random(seed));
      sel = 4'(($random(seed) & 255) % 4);
      @(negedge clk_sys_in);
      chk_val({7'h00, run_en}, {7'h00, run && sel == 4'h0});
    end
    reset_n_in = 1'b0;
    @(negedge clk_sys_in);
    chk_val({bf, sf, red, green, jstart, run_en, jset}, 8'h80);
    reset_n_in = 1'b1;
    end_of_test();
  end

  // Hang guard
  initial begin
    #900000;
    err_total++;
    end_of_test();
  end
endmodule // hub_status_indicator_jog_tb
